// ### rtl/osc_ctrl_pkg.sv
package osc_ctrl_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FDIV = 8'h04;
  localparam logic [7:0] OFF_SPRE = 8'h08;
  localparam logic [7:0] OFF_PCTL = 8'h0C;
  localparam logic [7:0] OFF_PRAT = 8'h10;
  localparam logic [7:0] OFF_PPRE = 8'h14;
  localparam logic [7:0] OFF_IEN = 8'h18;
  localparam logic [7:0] OFF_IFLG = 8'h1C;
  localparam logic [7:0] OFF_STAT = 8'h20;
  localparam logic [7:0] OFF_PMUL = 8'h24;
  // ---------------------------------------------------------------
  // field layouts and reset values
  // ---------------------------------------------------------------
  typedef struct packed {
    logic failEvEn;
    logic switch_back_enable;
    logic cfdEn;
    logic extOnDem;
    logic extStdby;
    logic extEn;
    logic fastOnDem;
    logic fastStdby;
    logic fastEn;
  } ctrl_t;
  localparam ctrl_t CTRL_RST = 9'h001;
  typedef struct packed {
    logic [1:0] out_prescale;
    logic [3:0] frac;
    logic [11:0] ratioInt;
    logic [2:0] lockTime;
    logic lockBypass;
    logic fastWakeup;
    logic [1:0] refSel;
    logic enable;
  } pll_cfg_t;
  localparam pll_cfg_t PLL_RST = 26'h0000000;
  localparam logic [1:0] REF_SLOW = 2'h0;
  localparam logic [1:0] REF_EXT = 2'h1;
  localparam logic [1:0] REF_GEN = 2'h2;
  localparam logic [3:0] FDIV_RST = 4'hB;
  localparam logic [2:0] FSTUP_RST = 3'h7;
  localparam int IRQ_FRDY = 0;
  localparam int IRQ_FAIL = 1;
  typedef enum logic [3:0] {
    P_OFF = 4'h1, P_START = 4'h2, P_ACQ = 4'h4, P_RUN = 4'h8
  } pll_st_t;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int FSTUP_STEP_NS = 1000;
  localparam int FSTUP_STEP_CYC = (FSTUP_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_NS = 60;
  localparam int SYNC_CYC = (SYNC_NS + CLK_NS - 1) / CLK_NS;
  localparam int STOP_NS = 160;
  localparam int STOP_CYC = (STOP_NS + CLK_NS - 1) / CLK_NS;
  localparam int EXT_STUP_US = 100;
  localparam int EXT_STUP_CYC = (EXT_STUP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int LOCK_STEP_US = 100;
  localparam int LOCK_STEP_CYC = (LOCK_STEP_US * 1000) / CLK_NS;
endpackage

// ### rtl/osc_ctrl_clock_fail_pll.sv
// The AHB-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// R1 - failure swaps external clock for safe clock and sets switched flag
// R2 - switching leaves the external oscillator enabled
// R3 - writing switch-back enable returns to external clock; hw clears it
// R4 - safe clock is fast oscillator divided by two to the prescale
// R5 - failure event only when enabled and not already switched
// R6 - detector follows external sleep rules; its flag wakes the device
// R7 - fast enable starts/stops it; clock out only when ready
// R8 - software checks ready is zero before enabling the fast oscillator
// R9 - fast oscillator enabled after reset at its reset divider
// R10 - fast run follows enable, on-demand, standby and requests
// R11 - fast output masked for start-up delay; then ready is set
// R12 - ready rising sets a flag raising interrupt when enabled
// R13 - software uses divider above zero with short start-up delays
// R14 - software keeps fast osc running until divider sync clears
// R15 - pll reference is slow crystal, external osc or generic clock
// R16 - pll ratio is integer plus one plus fraction over sixteen
// R17 - pll output held low while disabled
// R18 - zero fraction means integer mode, otherwise fractional mode
// R19 - pll enable change sets sync pending; clears on edge or stop
// R20 - non-zero lock time gives timed lock, zero uses core lock
// R21 - first output edge at lock, timer end, or start-up if fast wakeup
// R22 - after first edge output stops on lost lock unless bypassed
// R23 - fail unless ext rise and fall seen in every four safe periods
// R24 - no failure reported until external start-up time elapsed
// R25 - switching back to ext is glitch free; the move to safe waits only for safe clock low while fail is set, not for ext low
module osc_ctrl_clock_fail_pll
  import osc_ctrl_pkg::*;
#(
  parameter int EXT_STUP = EXT_STUP_CYC,
  parameter int LOCK_STEP = LOCK_STEP_CYC
)(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // oscillator pins and core
  input wire logic extOscClk,
  input wire logic fastOscClk,
  input wire logic pllRawClk,
  input wire logic pllCoreLock,
  // sleep and peripheral requests
  input wire logic standby,
  input wire logic extReq,
  input wire logic fastReq,
  // outputs
  output logic monClk,
  output logic failEvent,
  output logic extOscRun,
  output logic fastOscRun,
  output logic [3:0] fastOscDiv,
  output logic fastOscClkOut,
  output pll_cfg_t pllCfg,
  output logic pllFracMode,
  output logic pllGatedClk,
  output logic irq
);
  if (EXT_STUP < 1 || EXT_STUP > 65535 || LOCK_STEP < 1
      || LOCK_STEP > 9362)
  begin : g_badParam
    $error("count parameter out of range");
  end
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int NS = 4;
  logic [NS-1:0] pinIn;
  logic [NS-1:0] s1;
  logic [NS-1:0] s2;
  logic [NS-1:0] s3;
  assign pinIn = {pllCoreLock, pllRawClk, fastOscClk, extOscClk};
  for (genvar i = 0; i < NS; i++)
  begin : g_sync
    always_ff @(posedge mclk)
    begin
      if (!resetn)
      begin
        s1[i] <= 1'b0;
        s2[i] <= 1'b0;
        s3[i] <= 1'b0;
      end
      else
      begin
        s1[i] <= pinIn[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
      end
    end
  end
  logic extS, fastS, rawS, lockS;
  logic extRise, extFall, fastRise, rawRise;
  assign {lockS, rawS, fastS, extS} = s2;
  assign extRise = s2[0] & ~s3[0];
  assign extFall = ~s2[0] & s3[0];
  assign fastRise = s2[1] & ~s3[1];
  assign rawRise = s2[2] & ~s3[2];

  function automatic logic runRule(logic en, logic stdbyRun,
                                   logic onDem, logic req);
    if (!en)
      return 1'b0;
    if (standby && !stdbyRun)
      return req;
    return onDem ? req : 1'b1;
  endfunction
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  ctrl_t ctrl_r, ctrl_nxt;
  pll_cfg_t pll_r, pll_nxt;
  logic [3:0] fdiv_r, fdiv_nxt;
  logic [2:0] fstup_r, fstup_nxt;
  logic [2:0] spre_r, spre_nxt;
  logic [1:0] ien_r, ien_nxt, iflg_r, iflg_nxt;
  logic wrPend_r, wrPend_nxt;
  logic [7:0] wAddr_r, wAddr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [15:0] extCnt_r, extCnt_nxt, fCnt_r, fCnt_nxt;
  logic [1:0] win_r, win_nxt;
  logic sawR_r, sawR_nxt, sawF_r, sawF_nxt;
  logic fail_r, fail_nxt, sw_r, sw_nxt;
  logic selSafe_r, selSafe_nxt, monClk_r, monClk_nxt;
  logic [7:0] dCnt_r, dCnt_nxt;
  logic safe_r, safe_nxt, safeD_r;
  logic ev_r, ev_nxt, fRdy_r, fRdy_nxt, fClk_r, fClk_nxt;
  logic [1:0] fSync_r, fSync_nxt;
  pll_st_t st_r, st_nxt;
  logic [15:0] lt_r, lt_nxt;
  logic [3:0] idle_r, idle_nxt;
  logic pBusy_r, pBusy_nxt, pClk_r, pClk_nxt, frac_r, frac_nxt;
  logic irq_r, irq_nxt;
  logic acq_r, acq_nxt;

  logic wr, addrOk;
  logic extRun, fastRun, extDone, cfdAct, failSet, swDone;
  logic pEnChg, lock, gate;
  logic [15:0] fTarget;
  logic [16:0] mult;
  assign wr = wrPend_r;
  assign addrOk = hsel & hready & htrans[1];
  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    pll_nxt = pll_r;
    fdiv_nxt = fdiv_r;
    fstup_nxt = fstup_r;
    spre_nxt = spre_r;
    ien_nxt = ien_r;
    iflg_nxt = iflg_r;
    pEnChg = 1'b0;
    wrPend_nxt = addrOk & hwrite;
    wAddr_nxt = addrOk ? haddr[7:0] : wAddr_r;
    if (swDone)
      ctrl_nxt.switch_back_enable = 1'b0; // [R3]
    if (wr)
    begin
      unique case (wAddr_r)
        OFF_CTRL: ctrl_nxt = hwdata[8:0]; // [R7] [R2]
        OFF_FDIV:
        begin
          fdiv_nxt = hwdata[3:0];
          fstup_nxt = hwdata[10:8];
        end
        OFF_SPRE: spre_nxt = hwdata[2:0];
        OFF_PCTL:
        begin
          pEnChg = hwdata[0] != pll_r.enable;
          pll_nxt.enable = hwdata[0];
          if (hwdata[2:1] != 2'h3)
            pll_nxt.refSel = hwdata[2:1]; // [R15]
          pll_nxt.fastWakeup = hwdata[3];
          pll_nxt.lockBypass = hwdata[4];
          pll_nxt.lockTime = hwdata[7:5];
        end
        OFF_PRAT:
        begin
          pll_nxt.ratioInt = hwdata[11:0];
          pll_nxt.frac = hwdata[19:16];
        end
        OFF_PPRE: pll_nxt.out_prescale = hwdata[1:0];
        OFF_IEN: ien_nxt = hwdata[1:0];
        OFF_IFLG: iflg_nxt = iflg_r & ~hwdata[1:0];
        default: ;
      endcase
    end
    // set beats clear
    if (fRdy_nxt && !fRdy_r)
      iflg_nxt[IRQ_FRDY] = 1'b1; // [R12]
    if (failSet)
      iflg_nxt[IRQ_FAIL] = 1'b1; // [R6]
    irq_nxt = |(iflg_r & ien_r); // [R12] [R6]
    mult = {pll_r.ratioInt + 13'h0001, pll_r.frac}; // [R16]
    rdata_nxt = 32'h00000000;
    if (addrOk && !hwrite)
    begin
      unique case (haddr[7:0])
        OFF_CTRL: rdata_nxt[8:0] = ctrl_r;
        OFF_FDIV: rdata_nxt[10:0] = {fstup_r, 4'h0, fdiv_r};
        OFF_SPRE: rdata_nxt[2:0] = spre_r;
        OFF_PCTL: rdata_nxt[7:0] = pll_r[7:0];
        OFF_PRAT: rdata_nxt[19:0] = {pll_r.frac, 4'h0, pll_r.ratioInt};
        OFF_PPRE: rdata_nxt[1:0] = pll_r.out_prescale;
        OFF_IEN: rdata_nxt[1:0] = ien_r;
        OFF_IFLG: rdata_nxt[1:0] = iflg_r;
        OFF_STAT: rdata_nxt[6:0] = {frac_r, pBusy_r, |fSync_r,
                                    lock, sw_r, fail_r, fRdy_r};
        OFF_PMUL: rdata_nxt[16:0] = mult;
        default: ;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // clock fail detector and switch
  // ---------------------------------------------------------------
  always_comb
  begin
    extRun = runRule(ctrl_r.extEn, ctrl_r.extStdby,
                     ctrl_r.extOnDem, extReq); // [R6]
    extCnt_nxt = extCnt_r;
    if (!extRun)
      extCnt_nxt = 16'h0000;
    else if (extCnt_r != EXT_STUP[15:0])
      extCnt_nxt = extCnt_r + 16'h0001; // [R24]
    extDone = extCnt_r == EXT_STUP[15:0];
    cfdAct = ctrl_r.cfdEn & extRun & extDone; // [R24] [R6]
    win_nxt = win_r;
    sawR_nxt = sawR_r | extRise;
    sawF_nxt = sawF_r | extFall;
    fail_nxt = fail_r;
    if (!cfdAct)
    begin
      win_nxt = 2'h0;
      sawR_nxt = 1'b0;
      sawF_nxt = 1'b0;
      fail_nxt = 1'b0;
    end
    else if (safe_r && !safeD_r)
    begin
      win_nxt = win_r + 2'h1;
      if (win_r == 2'h3)
      begin
        fail_nxt = !(sawR_nxt && sawF_nxt); // [R23]
        sawR_nxt = 1'b0;
        sawF_nxt = 1'b0;
      end
    end
    failSet = fail_nxt & ~fail_r;
    // clear of switch_back_enable waits for the mux to really land on ext
    swDone = ctrl_r.switch_back_enable & sw_r & ~selSafe_r & ~failSet;
    sw_nxt = failSet | (sw_r & ~swDone); // [R1] [R3]
    ev_nxt = failSet & ctrl_r.failEvEn & ~sw_r; // [R5]
    selSafe_nxt = selSafe_r;
    // change select only while both sources are low; an ext clock
    // stuck high after failure must not hold off the move to safe
    if (!safe_r && (!extS || (fail_r && !selSafe_r)))
      selSafe_nxt = sw_r & ~ctrl_r.switch_back_enable; // [R25] [R1]
    monClk_nxt = selSafe_r ? safe_r : extS; // [R1]
  end
  // ---------------------------------------------------------------
  // fast oscillator and safe clock divider
  // ---------------------------------------------------------------
  always_comb
  begin
    fastRun = runRule(ctrl_r.fastEn, ctrl_r.fastStdby,
                      ctrl_r.fastOnDem, fastReq); // [R10] [R7]
    fTarget = 16'(({13'h0000, fstup_r} + 16'h0001)
                  * FSTUP_STEP_CYC);
    fCnt_nxt = fCnt_r;
    if (!fastRun)
      fCnt_nxt = 16'h0000;
    // compare by magnitude: a shorter delay written while running
    // must not send the count round the whole range
    else if (fCnt_r < fTarget)
      fCnt_nxt = fCnt_r + 16'h0001; // [R11]
    fRdy_nxt = fastRun & (fCnt_r >= fTarget); // [R11]
    fClk_nxt = fRdy_r & fastS; // [R7] [R11]
    fSync_nxt = (fSync_r == 2'h0) ? 2'h0 : fSync_r - 2'h1;
    if (wr && wAddr_r == OFF_FDIV && hwdata[3:0] != fdiv_r)
      fSync_nxt = 2'(SYNC_CYC);
    dCnt_nxt = (fRdy_r && fastRise) ? dCnt_r + 8'h01 : dCnt_r;
    safe_nxt = (spre_r == 3'h0) ? fastS
             : dCnt_r[spre_r - 3'h1]; // [R4]
  end
  // ---------------------------------------------------------------
  // pll gating
  // ---------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    lt_nxt = (lt_r != 16'h0000) ? lt_r - 16'h0001 : lt_r;
    lock = pll_r.enable & ((pll_r.lockTime == 3'h0) ? lockS
         : (st_r != P_OFF && lt_r == 16'h0000)); // [R20]
    unique case (st_r)
      P_OFF:
        if (pll_r.enable)
        begin
          st_nxt = P_START;
          lt_nxt = 16'(pll_r.lockTime * LOCK_STEP);
        end
      P_START:
        if (!pll_r.enable)
          st_nxt = P_OFF;
        else if (rawRise)
          st_nxt = pll_r.fastWakeup ? P_RUN : P_ACQ; // [R21]
      P_ACQ:
        if (!pll_r.enable)
          st_nxt = P_OFF;
        else if (lock)
          st_nxt = P_RUN; // [R21]
      P_RUN:
        if (!pll_r.enable)
          st_nxt = P_OFF;
    endcase
    // before the first acquisition (fast wakeup) lock does not gate
    acq_nxt = (st_r != P_OFF) & (acq_r | lock); // [R21]
    gate = pll_r.enable & (st_r == P_RUN)
         & (pll_r.lockBypass | lock | ~acq_r); // [R22] [R17]
    pClk_nxt = gate & rawS;
    idle_nxt = rawRise ? 4'h0
             : (idle_r == 4'(STOP_CYC)) ? idle_r : idle_r + 4'h1;
    pBusy_nxt = pBusy_r;
    if (pBusy_r && pll_r.enable && rawRise)
      pBusy_nxt = 1'b0; // [R19]
    if (pBusy_r && !pll_r.enable && idle_r == 4'(STOP_CYC))
      pBusy_nxt = 1'b0; // [R19]
    if (pEnChg)
      pBusy_nxt = 1'b1; // [R19]
    frac_nxt = pll_r.frac != 4'h0; // [R18]
  end
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      ctrl_r <= CTRL_RST; // [R9]
      pll_r <= PLL_RST;
      fdiv_r <= FDIV_RST; // [R9]
      fstup_r <= FSTUP_RST;
      spre_r <= 3'h0;
      ien_r <= 2'h0;
      iflg_r <= 2'h0;
      wrPend_r <= 1'b0;
      wAddr_r <= 8'h00;
      rdata_r <= 32'h00000000;
      extCnt_r <= 16'h0000;
      fCnt_r <= 16'h0000;
      win_r <= 2'h0;
      sawR_r <= 1'b0;
      sawF_r <= 1'b0;
      fail_r <= 1'b0;
      sw_r <= 1'b0;
      selSafe_r <= 1'b0;
      monClk_r <= 1'b0;
      dCnt_r <= 8'h00;
      safe_r <= 1'b0;
      safeD_r <= 1'b0;
      ev_r <= 1'b0;
      fRdy_r <= 1'b0;
      fClk_r <= 1'b0;
      fSync_r <= 2'h0;
      st_r <= P_OFF;
      lt_r <= 16'h0000;
      idle_r <= 4'h0;
      pBusy_r <= 1'b0;
      pClk_r <= 1'b0;
      acq_r <= 1'b0;
      frac_r <= 1'b0;
      irq_r <= 1'b0;
      extOscRun <= 1'b0;
      fastOscRun <= 1'b0;
      fastOscDiv <= FDIV_RST;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      pll_r <= pll_nxt;
      fdiv_r <= fdiv_nxt;
      fstup_r <= fstup_nxt;
      spre_r <= spre_nxt;
      ien_r <= ien_nxt;
      iflg_r <= iflg_nxt;
      wrPend_r <= wrPend_nxt;
      wAddr_r <= wAddr_nxt;
      rdata_r <= rdata_nxt;
      extCnt_r <= extCnt_nxt;
      fCnt_r <= fCnt_nxt;
      win_r <= win_nxt;
      sawR_r <= sawR_nxt;
      sawF_r <= sawF_nxt;
      fail_r <= fail_nxt;
      sw_r <= sw_nxt;
      selSafe_r <= selSafe_nxt;
      monClk_r <= monClk_nxt;
      dCnt_r <= dCnt_nxt;
      safe_r <= safe_nxt;
      safeD_r <= safe_r;
      ev_r <= ev_nxt;
      fRdy_r <= fRdy_nxt;
      fClk_r <= fClk_nxt;
      fSync_r <= fSync_nxt;
      st_r <= st_nxt;
      lt_r <= lt_nxt;
      idle_r <= idle_nxt;
      pBusy_r <= pBusy_nxt;
      pClk_r <= pClk_nxt;
      acq_r <= acq_nxt;
      frac_r <= frac_nxt;
      irq_r <= irq_nxt;
      extOscRun <= extRun; // [R2]
      fastOscRun <= fastRun;
      fastOscDiv <= fdiv_r;
    end
  end
  assign hrdata = rdata_r;
  assign hreadyout = resetn | ~resetn;
  assign hresp = 1'b0;
  assign monClk = monClk_r;
  assign failEvent = ev_r;
  assign fastOscClkOut = fClk_r;
  assign pllCfg = pll_r;
  assign pllFracMode = frac_r;
  assign pllGatedClk = pClk_r;
  assign irq = irq_r;
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_failSwitch;
    failSet |=> sw_r ##[1:40] selSafe_r;
  endproperty
  a_failSwitch: assert property (p_failSwitch) // [R1]
    else $error("no switch to safe clock after failure");
  property p_swBack;
    swDone |=> !sw_r && !ctrl_r.switch_back_enable;
  endproperty
  a_swBack: assert property (p_swBack) // [R3]
    else $error("switch back not completed");
  property p_event;
    ev_r |-> $past(failSet) && !$past(sw_r);
  endproperty
  a_event: assert property (p_event) // [R5]
    else $error("failure event while switched");
  property p_fastStop;
    !ctrl_r.fastEn |=> !fRdy_r ##1 !fClk_r;
  endproperty
  a_fastStop: assert property (p_fastStop) // [R10]
    else $error("fast osc not stopped");
  property p_fastMask;
    fastRun && fCnt_r == 16'h0000 |=> !fRdy_r [*2];
  endproperty
  a_fastMask: assert property (p_fastMask) // [R11]
    else $error("fast output not masked in start-up");
  property p_rdyIrq;
    $rose(fRdy_r) && ien_r[IRQ_FRDY] |=> ##1 irq_r;
  endproperty
  a_rdyIrq: assert property (p_rdyIrq) // [R12]
    else $error("ready interrupt missing");
  property p_pllLow;
    !pll_r.enable |=> !pClk_r;
  endproperty
  a_pllLow: assert property (p_pllLow) // [R17]
    else $error("pll output not low when disabled");
  property p_frac;
    $changed(pll_r.frac) |=> frac_r == (pll_r.frac != 4'h0);
  endproperty
  a_frac: assert property (p_frac) // [R18]
    else $error("fraction mode wrong");
  property p_busy;
    pEnChg |=> pBusy_r;
  endproperty
  a_busy: assert property (p_busy) // [R19]
    else $error("pll sync pending not set");
  property p_gate;
    st_r == P_RUN && acq_r && !lock && !pll_r.lockBypass |=> !pClk_r;
  endproperty
  a_gate: assert property (p_gate) // [R22]
    else $error("pll output ran without lock");
  property p_first;
    st_r == P_ACQ |-> !pClk_nxt;
  endproperty
  a_first: assert property (p_first) // [R21]
    else $error("pll edge before first-edge condition");
  c_fail: cover property (failSet ##[1:40] selSafe_r);
  c_back: cover property (swDone ##[1:40] !selSafe_r);
  c_pllRun: cover property (st_r == P_ACQ ##1 st_r == P_RUN);
  c_rdy: cover property ($rose(fRdy_r));
endmodule // osc_ctrl_clock_fail_pll

// ### tb/osc_ctrl_clock_fail_pll_bench.sv
`timescale 1ns/1ps
module osc_ctrl_clock_fail_pll_bench
  import osc_ctrl_pkg::*;
;
  // ---------------------------------------------------------------
  // stimulus and observation
  // ---------------------------------------------------------------
  typedef struct packed {logic [7:0] a; logic [31:0] wd, ex;} row_t;
  typedef struct packed {logic [8:0] ctl; logic sb, rq, run;} mode_t;
  logic mclk = 1'b0;
  logic resetn, hsel, hwrite, extOscClk, fastOscClk, pllRawClk;
  logic pllCoreLock, standby, extReq, fastReq, extTog, pllTog;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire logic hready;
  logic hreadyout, hresp, monClk, failEvent, extOscRun, fastOscRun;
  logic fastOscClkOut, pllFracMode, pllGatedClk, irq;
  logic [3:0] fastOscDiv;
  pll_cfg_t pllCfg;
  logic [7:0] tick = 8'h00;
  logic [2:0] gPrev = 3'h0;
  logic [15:0] gCnt = 16'h0000, fCnt = 16'h0000, eCnt = 16'h0000, c;
  logic [15:0] mCnt = 16'h0000;
  int numErrors = 0, nChecks = 0;
  row_t rows [0:10] = '{
    '{OFF_FDIV, 32'h00000305, 32'h00000305},
    '{OFF_SPRE, 32'h00000005, 32'h00000005},
    '{OFF_SPRE, 32'h00000000, 32'h00000000},
    '{OFF_PRAT, 32'h000305DB, 32'h000305DB},
    '{OFF_PMUL, 32'hFFFFFFFF, 32'h00005DC3},
    '{OFF_PPRE, 32'h00000003, 32'h00000003},
    '{OFF_PCTL, 32'h00000004, 32'h00000004},
    '{OFF_PCTL, 32'h00000006, 32'h00000004},
    '{OFF_PCTL, 32'h00000002, 32'h00000002},
    '{OFF_PCTL, 32'h00000000, 32'h00000000},
    '{8'h28, 32'hFFFFFFFF, 32'h00000000}};
  mode_t modes [0:6] = '{'{9'h001, 1'b0, 1'b0, 1'b1},
    '{9'h005, 1'b0, 1'b0, 1'b0}, '{9'h005, 1'b0, 1'b1, 1'b1},
    '{9'h001, 1'b1, 1'b0, 1'b0}, '{9'h003, 1'b1, 1'b0, 1'b1},
    '{9'h007, 1'b1, 1'b0, 1'b0}, '{9'h000, 1'b0, 1'b1, 1'b0}};

  assign hready = hreadyout;

  osc_ctrl_clock_fail_pll #(.EXT_STUP(20), .LOCK_STEP(10))
    osc_ctrl_clock_fail_pll_i (.mclk(mclk), .resetn(resetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .extOscClk(extOscClk),
    .fastOscClk(fastOscClk), .pllRawClk(pllRawClk),
    .pllCoreLock(pllCoreLock), .standby(standby), .extReq(extReq),
    .fastReq(fastReq), .monClk(monClk), .failEvent(failEvent),
    .extOscRun(extOscRun), .fastOscRun(fastOscRun),
    .fastOscDiv(fastOscDiv), .fastOscClkOut(fastOscClkOut),
    .pllCfg(pllCfg), .pllFracMode(pllFracMode),
    .pllGatedClk(pllGatedClk), .irq(irq));

  initial
    forever #10 mclk = ~mclk;

  // oscillator pins change only on the rising edge, like all stimulus
  always @(posedge mclk)
  begin
    tick <= tick + 8'h01;
    fastOscClk <= tick[1];
    extOscClk <= extTog & tick[1];
    // the core's raw clock stops while the block holds it disabled
    pllRawClk <= pllTog & pllCfg.enable & tick[1];
    gPrev <= {monClk, pllGatedClk, fastOscClkOut};
    mCnt <= mCnt + 16'(monClk & ~gPrev[2]);
    gCnt <= gCnt + 16'(pllGatedClk & ~gPrev[1]);
    fCnt <= fCnt + 16'(fastOscClkOut & ~gPrev[0]);
    eCnt <= eCnt + 16'(failEvent);
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    nChecks++;
    if (g !== e)
    begin
      numErrors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // no fixed latency assumed: both phases wait for hready
  task automatic ahb(input logic [7:0] a, input logic w,
    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    ahb(a, 1'b1, wd, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    ahb(a, 1'b0, 32'h00000000, x);
  endtask

  task automatic wst(input int b, input logic v, input int n);
    logic [31:0] x;
    for (int i = 0; i < n; i++)
    begin
      rd(OFF_STAT, x);
      if (x[b] === v)
        break;
    end
    chk("status bit", {31'h0, v}, {31'h0, x[b]});
  endtask

  task automatic edges(input string n, input logic exp, input int cyc);
    c = gCnt;
    repeat (cyc) @(posedge mclk);
    chk(n, {31'h0, exp}, {31'h0, gCnt != c});
  endtask

  task automatic stopTest;
    $display("checks %0d mismatches %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge mclk);
    numErrors++;
    stopTest;
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    {resetn, hsel, hwrite, pllCoreLock, standby, extReq} = 6'h00;
    {fastReq, extTog, pllTog} = 3'h0;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    hsel <= 1'b1;
    chk("reset div", 32'hB, fastOscDiv);
    rd(OFF_CTRL, d);
    chk("ctrl", 32'(CTRL_RST), d);
    rd(OFF_FDIV, d);
    chk("fdiv", 32'h0000070B, d);
    chk("fast run", 32'h1, fastOscRun);
    c = fCnt;
    repeat (100) @(posedge mclk);
    chk("masked clk", 32'(c), 32'(fCnt));
    wst(0, 1'b1, 300);
    c = fCnt;
    repeat (20) @(posedge mclk);
    chk("fast out", 32'h1, 32'(fCnt != c));
    $display("test reset done");
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].wd);
      rd(rows[i].a, d);
      chk("reg row", rows[i].ex, d);
    end
    chk("frac mode", 32'h1, pllFracMode);
    chk("pll cfg", 32'h0335DB00, 32'(pllCfg));
    chk("div out", 32'h5, fastOscDiv);
    $display("test registers done");
    foreach (modes[i])
    begin
      wr(OFF_CTRL, {23'h0, modes[i].ctl});
      standby <= modes[i].sb;
      fastReq <= modes[i].rq;
      repeat (4) @(posedge mclk);
      chk("fast run mode", {31'h0, modes[i].run}, fastOscRun);
    end
    {standby, fastReq} <= 2'h0;
    $display("test run modes done");
    wr(OFF_IFLG, 32'h3);
    wst(0, 1'b0, 20);
    wr(OFF_IEN, 32'h1);
    chk("irq off", 32'h0, irq);
    wr(OFF_CTRL, 32'h1);
    wst(0, 1'b1, 300);
    repeat (2) @(posedge mclk);
    chk("irq on", 32'h1, irq);
    wr(OFF_IFLG, 32'h1);
    repeat (2) @(posedge mclk);
    chk("irq clear", 32'h0, irq);
    $display("test ready irq done");
    extTog <= 1'b1;
    wr(OFF_CTRL, 32'h00000149);
    repeat (100) @(posedge mclk);
    wst(2, 1'b0, 1);
    c = eCnt;
    extTog <= 1'b0;
    wst(2, 1'b1, 200);
    chk("ext kept", 32'h1, extOscRun);
    repeat (100) @(posedge mclk);
    chk("one event", 32'h1, 32'(eCnt - c));
    c = mCnt;
    repeat (64) @(posedge mclk);
    chk("safe edges", 32'h10, 32'(mCnt - c));
    wr(OFF_SPRE, 32'h1);
    repeat (8) @(posedge mclk);
    c = mCnt;
    repeat (64) @(posedge mclk);
    chk("safe div", 32'h8, 32'(mCnt - c));
    rd(OFF_IFLG, d);
    chk("fail flag", 32'h1, {31'h0, d[IRQ_FAIL]});
    extTog <= 1'b1;
    wr(OFF_CTRL, 32'h000001C9);
    wst(2, 1'b0, 200);
    rd(OFF_CTRL, d);
    chk("switch_back_enable clear", 32'h00000149, d);
    $display("test failure done");
    wr(OFF_PCTL, 32'h1);
    wst(5, 1'b1, 20);
    pllTog <= 1'b1;
    wst(5, 1'b0, 50);
    edges("pre lock", 1'b0, 60);
    pllCoreLock <= 1'b1;
    edges("locked", 1'b1, 60);
    pllCoreLock <= 1'b0;
    repeat (10) @(posedge mclk);
    edges("lost lock", 1'b0, 40);
    wr(OFF_PCTL, 32'h11);
    edges("bypass", 1'b1, 40);
    wr(OFF_PCTL, 32'h0);
    repeat (20) @(posedge mclk);
    wst(5, 1'b0, 20);
    edges("disabled", 1'b0, 40);
    chk("low out", 32'h0, pllGatedClk);
    wr(OFF_PCTL, 32'h21);
    edges("lock timer", 1'b1, 80);
    wr(OFF_PCTL, 32'h0);
    repeat (20) @(posedge mclk);
    wr(OFF_PCTL, 32'h9);
    edges("fast wakeup", 1'b1, 60);
    wr(OFF_PRAT, 32'h000005DB);
    repeat (2) @(posedge mclk);
    chk("int mode", 32'h0, pllFracMode);
    $display("test pll done");
    stopTest;
  end
endmodule // osc_ctrl_clock_fail_pll_bench
